// ---- common/bcst_map.svh ----
`ifndef BCST_MAP_SVH
`define BCST_MAP_SVH

// ************************************************************
// geometry
// ************************************************************
`define BCST_SR_LEN 64
`define BCST_SCORE_W 7
`define BCST_FIFO_DEPTH 8

// ************************************************************
// shift register lane positions
// ************************************************************
`define BCST_LANE_A 0
`define BCST_LANE_B 1
`define BCST_LANE_M 2
`define BCST_LANES 3

// ************************************************************
// reset values
// ************************************************************
`define BCST_SR_RST 64'h0000_0000_0000_0000
`define BCST_SCORE_RST 7'h00
`define BCST_THR_RST 7'h00

`endif

// ---- common/bcst_pkg.sv ----
package bcst_pkg;

  // one serial bit per shift register
  typedef struct packed {
    logic m;
    logic b;
    logic a;
  } bcst_serial_s;

  // strobes standing for the per-register clocks
  typedef struct packed {
    logic sum;
    logic thr;
    logic m;
    logic b;
    logic a;
  } bcst_clks_s;

  // static controls
  typedef struct packed {
    logic float_out;
    logic invert;
    logic ref_load;
  } bcst_ctrl_s;

  typedef logic [6:0] bcst_score_t;

endpackage

// ---- dv/bcst_host.sv ----
`timescale 1ns/1ps
// ************************************************************
// host logic on the far side of the correlator
// ************************************************************
module bcst_host (
  // clock
  input wire logic i_mclk,
  // score pins as the device drives them
  input wire logic [6:0] i_score_out,
  input wire logic i_score_oe,
  // host drives
  output bcst_pkg::bcst_serial_s o_serial,
  output bcst_pkg::bcst_clks_s o_clks,
  output bcst_pkg::bcst_ctrl_s o_ctrl,
  output logic [6:0] o_score_in
);
  logic [63:0] sr [3];
  logic [63:0] lat;
  logic [6:0] drv;
  logic drv_en;
  logic [6:0] last_q = 7'h00;

  initial
  begin
    o_serial = 3'h0;
    o_clks = 5'h00;
    o_ctrl = 3'h0;
    drv = 7'h00;
    drv_en = 1'b0;
    lat = 64'h0;
    foreach (sr[i])
      sr[i] = 64'h0;
  end

  // no pull on the pins: a released pin shows a changing pattern
  assign o_score_in = i_score_oe ? i_score_out : (drv_en ? drv : ~last_q);
  always @(posedge i_mclk)
    last_q <= o_score_in;

  task automatic pulse(input int idx);
    @(posedge i_mclk) o_clks[idx] <= 1'b1;
    @(posedge i_mclk) o_clks[idx] <= 1'b0;
  endtask

  // data bit is set one edge ahead and held past the strobe edge
  task automatic shift(input int lane, input logic b);
    @(posedge i_mclk) o_serial[lane] <= b;
    pulse(lane);
    sr[lane] = {sr[lane][62:0], b};
  endtask

  task automatic load(input int lane, input logic [63:0] w);
    for (int i = 63; i >= 0; i--)
      shift(lane, w[i]);
  endtask

  task automatic latch_ref();
    @(posedge i_mclk) o_ctrl.ref_load <= 1'b1;
    @(posedge i_mclk);
    @(posedge i_mclk) o_ctrl.ref_load <= 1'b0;
    lat = sr[1];
  endtask

  // pins floated first so the capture edge sees only the host value
  task automatic set_thr(input logic [6:0] t);
    @(posedge i_mclk)
    begin
      o_ctrl.float_out <= 1'b1;
      drv_en <= 1'b1;
      drv <= t;
    end
    pulse(3);
    @(posedge i_mclk)
    begin
      drv_en <= 1'b0;
      o_ctrl.float_out <= 1'b0;
    end
  endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module tb_top;
  logic i_mclk;
  logic i_rst_n;
  bcst_pkg::bcst_serial_s serial;
  bcst_pkg::bcst_clks_s clks;
  bcst_pkg::bcst_ctrl_s ctrl;
  logic [6:0] score_in;
  logic [6:0] score_out;
  logic score_oe;
  logic thr_hit;
  bcst_pkg::bcst_serial_s ser_out;
  logic sum_ready;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [6:0] s;
  logic [6:0] prev;
  logic [63:0] w;
  logic [6:0] thr_tab [4];
  logic [6:0] got [$];

  bcst_core dut_u (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_serial(serial),
    .i_clks(clks),
    .i_ctrl(ctrl),
    .i_score_in(score_in),
    .o_score_out(score_out),
    .o_score_oe(score_oe),
    .o_thr_hit(thr_hit),
    .o_serial(ser_out),
    .o_sum_ready(sum_ready)
  );

  bcst_host host_u (
    .i_mclk(i_mclk),
    .i_score_out(score_out),
    .i_score_oe(score_oe),
    .o_serial(serial),
    .o_clks(clks),
    .o_ctrl(ctrl),
    .o_score_in(score_in)
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // the run needs about 1900 cycles
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      failures++;
      finish_test();
    end
  end

  function automatic logic [6:0] score(input logic [63:0] a, r, m);
    logic [6:0] k;
    k = 7'h00;
    for (int i = 0; i < 64; i++)
      k += 7'((a[i] ~^ r[i]) & m[i]);
    return k;
  endfunction

  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check_score(input logic [6:0] thr, input logic invert);
    logic [6:0] e;
    e = score(host_u.sr[0], host_u.lat, host_u.sr[2]);
    host_u.pulse(4);
    repeat (3) @(posedge i_mclk);
    #1;
    `CHK(score_out, invert ? ~e : e)
    `CHK(thr_hit, e >= thr)
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    `CHK(score_out, 7'h00)
    `CHK(ser_out, 3'h0)
    `CHK(sum_ready, 1'b1)
    `CHK(score_oe, 1'b1)
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    host_u.load(2, 64'hffff_0000_ffff_ffff);
    host_u.load(0, 64'h0123_4567_89ab_cdef);
    host_u.load(1, 64'h0f1e_2d3c_4b5a_6978);
    host_u.latch_ref();
    s = score(host_u.sr[0], host_u.lat, host_u.sr[2]);
    thr_tab = '{7'h00, s, s + 7'h01, 7'h40};
    foreach (thr_tab[i])
    begin
      host_u.set_thr(thr_tab[i]);
      check_score(thr_tab[i], 1'b0);
    end
    $display("test 1 done");
    @(posedge i_mclk) host_u.o_ctrl.float_out <= 1'b1;
    @(posedge i_mclk) host_u.o_ctrl.invert <= 1'b1;
    #1;
    `CHK(score_oe, 1'b0)
    @(posedge i_mclk) host_u.o_ctrl.float_out <= 1'b0;
    check_score(7'h40, 1'b1);
    @(posedge i_mclk) host_u.o_ctrl.invert <= 1'b0;
    $display("test 2 done");
    for (int l = 0; l < 3; l++)
    begin
      w = host_u.sr[l];
      host_u.load(l, ~w);
      @(posedge i_mclk);
      #1;
      // the bit a chained next device would take in
      `CHK(ser_out[l], w[0])
      check_score(7'h40, 1'b0);
    end
    host_u.latch_ref();
    check_score(7'h40, 1'b0);
    $display("test 3 done");
    // latch all ones, mask all ones: each 1 shifted into A adds one
    host_u.load(1, 64'hffff_ffff_ffff_ffff);
    host_u.latch_ref();
    host_u.load(0, 64'h0);
    host_u.load(2, 64'hffff_ffff_ffff_ffff);
    check_score(7'h40, 1'b0);
    prev = score_out;
    @(posedge i_mclk) host_u.o_ctrl.float_out <= 1'b1;
    n = 0;
    while (sum_ready === 1'b1 && n < 12)
    begin
      host_u.shift(0, 1'b1);
      host_u.pulse(4);
      @(posedge i_mclk);
      #1;
      n++;
    end
    `CHK(n, 8)
    host_u.shift(0, 1'b1);
    host_u.pulse(4);
    @(posedge i_mclk) host_u.o_ctrl.float_out <= 1'b0;
    repeat (30)
    begin
      @(posedge i_mclk);
      #1;
      if (score_out !== prev)
        got.push_back(score_out);
      prev = score_out;
    end
    `CHK(got.size(), 8)
    foreach (got[i])
      `CHK(got[i], 7'(i + 1))
    $display("test 4 done");
    finish_test();
  end
endmodule

// ---- logic/bcst_core.sv ----
// Function
// - reference bits shift into 64-bit register
// - score pins drive masked agreement count
// - score pins double as threshold input
// - threshold captured on threshold clock rise
// - flag high when score meets threshold
// - each shift register has serial output
// - float control tristates the score pins
// - invert control complements driven score
// - zero mask bit excludes that position
// - reference latch transparent while load high; here a register that copies b one cycle late
`timescale 1ns/1ps
`include "bcst_map.svh"
module bcst_core (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // serial inputs and register strobes
  input wire bcst_pkg::bcst_serial_s i_serial,
  input wire bcst_pkg::bcst_clks_s i_clks,
  // controls
  input wire bcst_pkg::bcst_ctrl_s i_ctrl,
  // score pins, three signals of a two-way pin
  input wire logic [`BCST_SCORE_W-1:0] i_score_in,
  output logic [`BCST_SCORE_W-1:0] o_score_out,
  output logic o_score_oe,
  // flag, cascade outputs, summer back-pressure
  output logic o_thr_hit,
  output bcst_pkg::bcst_serial_s o_serial,
  output logic o_sum_ready
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [`BCST_SCORE_W-1:0] count_ones(input logic [`BCST_SR_LEN-1:0] v);
    logic [`BCST_SCORE_W-1:0] n;
    n = `BCST_SCORE_RST;
    for (int i = 0; i < `BCST_SR_LEN; i++)
    begin
      n = n + {{(`BCST_SCORE_W-1){1'b0}}, v[i]};
    end
    return n;
  endfunction

  function automatic logic rising(input logic now, input logic prev);
    return now && !prev;
  endfunction

  // ************************************************************
  // reset release
  // ************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // strobe edges
  // ************************************************************
  // the register clocks arrive as sampled levels, so each acts on its rising edge
  bcst_pkg::bcst_clks_s clks_q;
  logic [`BCST_LANES-1:0] sr_rise;
  logic sum_rise;
  logic thr_rise;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clks_q <= '0;
    end
    else
    begin
      clks_q <= i_clks;
    end
  end

  assign sr_rise[`BCST_LANE_A] = rising(i_clks.a, clks_q.a);
  assign sr_rise[`BCST_LANE_B] = rising(i_clks.b, clks_q.b);
  assign sr_rise[`BCST_LANE_M] = rising(i_clks.m, clks_q.m);
  assign sum_rise = rising(i_clks.sum, clks_q.sum);
  assign thr_rise = rising(i_clks.thr, clks_q.thr);

  // ************************************************************
  // shift registers
  // ************************************************************
  logic [`BCST_LANES-1:0] sr_in;
  logic [`BCST_SR_LEN-1:0] sr_q [`BCST_LANES];
  logic [`BCST_LANES-1:0] sr_out_q;

  assign sr_in = {i_serial.m, i_serial.b, i_serial.a};

  for (genvar g = 0; g < `BCST_LANES; g++)
  begin : g_sr
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        sr_q[g] <= `BCST_SR_RST;
        sr_out_q[g] <= 1'b0;
      end
      else if (sr_rise[g])
      begin
        sr_q[g] <= {sr_q[g][`BCST_SR_LEN-2:0], sr_in[g]};
        sr_out_q[g] <= sr_q[g][`BCST_SR_LEN-1];
      end
    end
  end

  // cascade outputs carry the bit pushed off the far end
  assign o_serial.a = sr_out_q[`BCST_LANE_A];
  assign o_serial.b = sr_out_q[`BCST_LANE_B];
  assign o_serial.m = sr_out_q[`BCST_LANE_M];

  // ************************************************************
  // reference latch
  // ************************************************************
  // a true latch is avoided; the copy trails the b register by one cycle
  logic [`BCST_SR_LEN-1:0] ref_q;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_q <= `BCST_SR_RST;
    end
    else if (i_ctrl.ref_load)
    begin
      ref_q <= sr_q[`BCST_LANE_B];
    end
  end

  // ************************************************************
  // agreement and summer
  // ************************************************************
  logic [`BCST_SR_LEN-1:0] agree;
  logic [`BCST_SCORE_W-1:0] sum_d;
  logic sum_push;
  logic fifo_valid;
  logic fifo_pop;
  logic [`BCST_SCORE_W-1:0] fifo_data;

  assign agree = ~(sr_q[`BCST_LANE_A] ^ ref_q) & sr_q[`BCST_LANE_M];
  assign sum_d = count_ones(agree);
  assign sum_push = sum_rise && o_sum_ready;
  // scores wait while the pins are floated for a threshold load
  assign fifo_pop = !i_ctrl.float_out;

  bcst_fifo #(
    .WIDTH(`BCST_SCORE_W),
    .DEPTH(`BCST_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_in_valid(sum_rise),
    .o_in_ready(o_sum_ready),
    .i_in_data(sum_d),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  // ************************************************************
  // score and threshold registers
  // ************************************************************
  logic [`BCST_SCORE_W-1:0] score_q;
  logic [`BCST_SCORE_W-1:0] thr_q;
  logic [`BCST_SCORE_W-1:0] pins_q;
  logic hit_q;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      score_q <= `BCST_SCORE_RST;
    end
    else if (fifo_valid && fifo_pop)
    begin
      score_q <= fifo_data;
    end
  end

  // latched whether or not we float; a load while driving reads back our own score
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      thr_q <= `BCST_THR_RST;
    end
    else if (thr_rise)
    begin
      thr_q <= i_score_in;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hit_q <= 1'b0;
    end
    else
    begin
      hit_q <= (score_q >= thr_q);
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_q <= `BCST_SCORE_RST;
    end
    else
    begin
      pins_q <= i_ctrl.invert ? ~score_q : score_q;
    end
  end

  assign o_score_out = pins_q;
  assign o_score_oe = !i_ctrl.float_out;
  assign o_thr_hit = hit_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_n);

  a_ref_shift_in: assert property (sr_rise[`BCST_LANE_B] |=>
    sr_q[`BCST_LANE_B][0] == $past(i_serial.b) &&
    sr_q[`BCST_LANE_B][`BCST_SR_LEN-1:1] == $past(sr_q[`BCST_LANE_B][`BCST_SR_LEN-2:0]))
  else $error("reference register did not shift in the serial bit");

  a_score_drive: assert property (!i_ctrl.float_out ##1 !i_ctrl.invert |=>
    o_score_oe == !i_ctrl.float_out && o_score_out == $past(score_q))
  else $error("driven score does not match registered score");

  a_thr_capture: assert property (thr_rise |=> thr_q == $past(i_score_in))
  else $error("threshold not captured from score pins");

  a_thr_hold: assert property (!thr_rise |=> $stable(thr_q))
  else $error("threshold changed without a threshold clock rise");

  // the flag resets low while score and threshold reset equal, so the first edge is skipped
  a_hit_flag: assert property (rst_n |=>
    o_thr_hit == ($past(score_q) >= $past(thr_q)))
  else $error("threshold flag disagrees with score and threshold");

  a_cascade_out: assert property (sr_rise[`BCST_LANE_A] |=>
    o_serial.a == $past(sr_q[`BCST_LANE_A][`BCST_SR_LEN-1]))
  else $error("data cascade output is not the shifted-out bit");

  a_cascade_ref: assert property (sr_rise[`BCST_LANE_B] |=>
    o_serial.b == $past(sr_q[`BCST_LANE_B][`BCST_SR_LEN-1]))
  else $error("reference cascade output is not the shifted-out bit");

  a_cascade_mask: assert property (sr_rise[`BCST_LANE_M] |=>
    o_serial.m == $past(sr_q[`BCST_LANE_M][`BCST_SR_LEN-1]))
  else $error("mask cascade output is not the shifted-out bit");

  a_cascade_hold: assert property (!sr_rise[`BCST_LANE_A] |=> $stable(o_serial.a))
  else $error("data cascade output moved without a shift");

  a_pins_driven: assert property (!i_ctrl.float_out |-> o_score_oe)
  else $error("score pins not driven while float control is low");

  a_float_pins: assert property (i_ctrl.float_out |-> !o_score_oe)
  else $error("score pins driven while floated");

  a_invert_out: assert property (i_ctrl.invert |=> o_score_out == ~$past(score_q))
  else $error("inverted score is not the complement");

  a_mask_zero: assert property (
    sr_q[`BCST_LANE_M] == `BCST_SR_RST |-> sum_d == `BCST_SCORE_RST)
  else $error("masked positions contributed to the score");

  a_latch_follow: assert property (i_ctrl.ref_load |=> ref_q == $past(sr_q[`BCST_LANE_B]))
  else $error("reference latch not transparent while load is high");

  a_latch_hold: assert property (!i_ctrl.ref_load |=> $stable(ref_q))
  else $error("reference latch changed while load is low");

  a_sum_to_score: assert property ((sum_push && !fifo_valid && !i_ctrl.float_out)
    ##1 !i_ctrl.float_out |=> score_q == $past(sum_d, 2))
  else $error("summer capture did not reach the score register");

  a_score_stable: assert property (!(fifo_valid && fifo_pop) |=> $stable(score_q))
  else $error("score moved without a summer entry");

  c_hit_rise: cover property ($rose(o_thr_hit));
  c_thr_load: cover property (i_ctrl.float_out && thr_rise);
  c_fifo_full: cover property (sum_rise && !o_sum_ready);
  c_invert_drive: cover property (i_ctrl.invert && o_score_oe && sum_push);

endmodule

// ---- logic/bcst_fifo.sv ----
`timescale 1ns/1ps
module bcst_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;
  assign o_out_data = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule
